//--- dv/isp_bank_props.sv
// Checker of bus timing, mode decode, measurement and fault flag at the bank's ports.
`timescale 1ns/10ps
module isp_bank_props
  import isp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic output_measure_i,
  input wire logic cycle_start_i,
  input wire logic sync_late_i,
  input wire logic mode_free_run_o,
  input wire logic mode_sm3_event_o,
  input wire logic mode_dc_sync0_o,
  input wire logic mode_dc_sync1_o,
  input wire logic mode_sm2_event_o,
  input wire logic measuring_o,
  input wire logic [31:0] cycle_period_o,
  input wire logic sync_fault_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Completing accesses and DC mode seen at the ports.
  wire wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i == 4'hF;
  wire rd_done = avs_read_i && !avs_waitrequest_o;
  wire dc_mode = mode_dc_sync0_o || mode_dc_sync1_o;
  wire [4:0] mode_vec = {mode_free_run_o, mode_sm3_event_o, mode_dc_sync0_o, mode_dc_sync1_o, mode_sm2_event_o};
  one_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("access not answered after one wait state");
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  rd_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");
  header_value_a: assert property (rd_done && avs_address_i == OFF_GROUP_HEADER
    |-> avs_readdata_o == 32'h00000020)
    else $error("group header read wrong");
  map_value_a: assert property (rd_done && avs_address_i == OFF_SUPPORTED_MAP
    |-> avs_readdata_o == 32'h0000C007)
    else $error("supported map read wrong");
  mode_decode_a: assert property (wr_done && avs_address_i == OFF_MODE_SELECT && avs_writedata_i == 32'h2
    |-> ##2 mode_dc_sync0_o)
    else $error("mode 2 not decoded");
  mode_sm2_a: assert property (wr_done && avs_address_i == OFF_MODE_SELECT && avs_writedata_i == 32'h22
    |-> ##2 mode_sm2_event_o)
    else $error("mode 34 not decoded");
  mode_onehot_a: assert property ($past(rstn_i) |-> $onehot(mode_vec))
    else $error("mode outputs not one-hot");
  period_copy_a: assert property (wr_done && avs_address_i == OFF_CYCLE_PERIOD
    |-> ##2 cycle_period_o == $past(avs_writedata_i, 2))
    else $error("cycle period output not updated");
  measure_on_a: assert property (output_measure_i |=> measuring_o)
    else $error("measurement not active with output side command");
  fault_set_a: assert property (cycle_start_i && sync_late_i && dc_mode |=> sync_fault_o)
    else $error("sync fault not set");
  fault_clr_a: assert property (cycle_start_i && !dc_mode |=> !sync_fault_o)
    else $error("sync fault set outside DC mode");
  rd_cov: cover property (rd_done);
  fault_cov: cover property (sync_fault_o);
  measure_cov: cover property (measuring_o);
endmodule
bind isp_bank isp_bank_props isp_bank_props_inst (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .output_measure_i(output_measure_i), .cycle_start_i(cycle_start_i), .sync_late_i(sync_late_i),
  .mode_free_run_o(mode_free_run_o), .mode_sm3_event_o(mode_sm3_event_o), .mode_sm2_event_o(mode_sm2_event_o),
  .mode_dc_sync0_o(mode_dc_sync0_o), .mode_dc_sync1_o(mode_dc_sync1_o), .measuring_o(measuring_o),
  .cycle_period_o(cycle_period_o), .sync_fault_o(sync_fault_o));

//--- dv/isp_event_src.sv
// Event source model that pulses the synchronisation and fault events of the bank.
`timescale 1ns/10ps
module isp_event_src (
  input wire logic clk_i,
  output logic [8:0] ev_o
);
  // Bits: 0 sync0, 1 sync1, 2 cycle start, 3 sampled, 4 available, 5 missed, 6 overrun, 7 short, 8 late.
  initial ev_o = '0;
  // One-cycle pulse, then one idle cycle so the next pulse is a fresh edge.
  task automatic fire(input logic [8:0] ev);
    ev_o <= ev;
    @(posedge clk_i);
    ev_o <= '0;
    @(posedge clk_i);
  endtask
  // A cycle with sync1 two clocks after sync0, sampling ds clocks after sync0, availability ds clocks later.
  task automatic run_cycle(input int ds);
    fire(9'h005);
    fire(9'h002);
    repeat (ds - 4) @(posedge clk_i);
    fire(9'h008);
    repeat (ds - 2) @(posedge clk_i);
    fire(9'h010);
  endtask
endmodule

//--- dv/tb.sv
// Self-checking testbench of the input synchronisation parameter bank.
`timescale 1ns/10ps
module tb;
  import isp_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i;
  logic [ADDR_W-1:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic operational_i;
  logic output_measure_i;
  logic [15:0] mode_codes [5] = '{16'h0000, 16'h0001, 16'h0003, 16'h0022, 16'h0002};
  logic [8:0] ev;
  logic mode_free_run_o, mode_sm3_event_o, mode_dc_sync0_o, mode_dc_sync1_o, mode_sm2_event_o, measuring_o;
  logic [31:0] cycle_period_o;
  logic sync_fault_o;
  logic [31:0] exp_q[$];
  logic [31:0] rnd;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_miss = 0;
  int n_over = 0;
  int n_short = 0;
  // Clock at 10 MHz.
  always #50 clk_i = ~clk_i;
  isp_event_src isp_event_src_inst (.clk_i(clk_i), .ev_o(ev));
  isp_bank isp_bank_inst (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .operational_i(operational_i),
    .sync0_i(ev[0]), .sync1_i(ev[1]), .cycle_start_i(ev[2]), .inputs_sampled_i(ev[3]),
    .inputs_available_i(ev[4]), .sm_event_missed_i(ev[5]), .cycle_overrun_i(ev[6]),
    .shift_too_short_i(ev[7]), .sync_late_i(ev[8]), .output_measure_i(output_measure_i),
    .mode_free_run_o(mode_free_run_o), .mode_sm3_event_o(mode_sm3_event_o), .mode_dc_sync0_o(mode_dc_sync0_o),
    .mode_dc_sync1_o(mode_dc_sync1_o), .mode_sm2_event_o(mode_sm2_event_o), .measuring_o(measuring_o),
    .cycle_period_o(cycle_period_o), .sync_fault_o(sync_fault_o));
  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One bus access held until waitrequest is sampled low, then released for one idle cycle.
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do @(negedge clk_i); while (avs_waitrequest_o !== 1'b0);
    @(posedge clk_i);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  // A read whose expected value is noted for the monitor.
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  // Monitor: takes the oldest note whenever a read completes.
  always @(posedge clk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
      num_checks++;
      if (exp_q.size() == 0 || avs_readdata_o !== exp_q[0]) begin
        n_mismatch++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, avs_readdata_o, exp_q.size() ? exp_q[0] : 32'h0);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end
  // Cuts a hang short.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(87798));
    rstn_i <= 1'b0;
    avs_address_i <= '0;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    avs_writedata_i <= '0;
    avs_byteenable_i <= 4'hF;
    operational_i <= 1'b0;
    output_measure_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    // Reset values, then writes to read-only entries that must leave them.
    for (int k = 0; k < 2; k++) begin
      rd(OFF_GROUP_HEADER, 32'h20);
      rd(OFF_MODE_SELECT, 32'h22);
      rd(OFF_SUPPORTED_MAP, 32'hC007);
      rd(OFF_PROFILE_HEADER, 32'h02);
      rd(OFF_CHANNEL_SPACING, 32'h10);
      rd(OFF_CHANNEL_COUNT, 32'h02);
      rd(OFF_SHIFT_NS, 32'h0);
      rd(OFF_MISSED_COUNT, 32'h0);
      for (int a = 0; a < 16; a++) begin
        if (a != 1 && a != 2 && a != 7) wr(ADDR_W'(a * 4), $urandom());
      end
    end
    // Every mode code, then an undefined code that is refused.
    foreach (mode_codes[i]) begin
      wr(OFF_MODE_SELECT, {16'h0000, mode_codes[i]});
      rd(OFF_MODE_SELECT, {16'h0000, mode_codes[i]});
    end
    wr(OFF_MODE_SELECT, 32'h5);
    rd(OFF_MODE_SELECT, 32'h2);
    // Cycle period with full and partial byte enables.
    rnd = $urandom();
    wr(OFF_CYCLE_PERIOD, rnd);
    bus(1'b1, OFF_CYCLE_PERIOD, 32'hA5A5A5A5, 4'h3);
    rd(OFF_CYCLE_PERIOD, {rnd[31:16], 16'hA5A5});
    // Profile storage above the timing entries: reset values and a random code word.
    rd(IDX_LIST_COUNT[ADDR_W-1:0], {24'h000000, RST_LIST_COUNT});
    rd(IDX_LIST_TWO[ADDR_W-1:0], RST_LIST_TWO);
    wr(IDX_CODE_WORD[ADDR_W-1:0], rnd);
    rd(IDX_CODE_WORD[ADDR_W-1:0], rnd);
    // Measurement keeps maxima, stops on 0 and clears on restart.
    wr(OFF_MEASURE_CMD, 32'h1);
    isp_event_src_inst.run_cycle(6);
    isp_event_src_inst.run_cycle(4);
    wr(OFF_MEASURE_CMD, 32'h0);
    isp_event_src_inst.run_cycle(8);
    rd(OFF_SHIFT_NS, 32'h0000_01F4);
    rd(OFF_SYNC1_DELAY_NS, 32'h0000_012C);
    rd(OFF_LATENCY_NS, 32'h0000_01F4);
    rd(OFF_MIN_CYCLE_NS, 32'h0000_044C);
    wr(OFF_MODE_SELECT, 32'h22);
    output_measure_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    isp_event_src_inst.run_cycle(4);
    output_measure_i <= 1'b0;
    rd(OFF_SHIFT_NS, 32'h0);
    rd(OFF_LATENCY_NS, 32'h0);
    rd(OFF_MIN_CYCLE_NS, 32'h0000_02BC);
    // Error counters against mode and operational state.
    wr(OFF_MODE_SELECT, 32'h2);
    operational_i <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rnd = $urandom();
      isp_event_src_inst.fire({1'b0, rnd[2:0], 5'h00});
      n_miss += rnd[0];
      n_over += rnd[1];
      n_short += rnd[2];
    end
    wr(OFF_MODE_SELECT, 32'h22);
    isp_event_src_inst.fire(9'h0E0);
    operational_i <= 1'b0;
    isp_event_src_inst.fire(9'h0E0);
    rd(OFF_MISSED_COUNT, 32'(n_miss));
    rd(OFF_OVERRUN_COUNT, 32'(n_over + 1));
    rd(OFF_SHORT_SHIFT_COUNT, 32'(n_short));
    // Sync fault flag: late before start, clean cycle, coincidence, and outside DC mode.
    wr(OFF_MODE_SELECT, 32'h2);
    isp_event_src_inst.fire(9'h004);
    isp_event_src_inst.fire(9'h100);
    isp_event_src_inst.fire(9'h004);
    rd(OFF_SYNC_FAULT, 32'h1);
    isp_event_src_inst.fire(9'h004);
    rd(OFF_SYNC_FAULT, 32'h0);
    isp_event_src_inst.fire(9'h104);
    rd(OFF_SYNC_FAULT, 32'h1);
    wr(OFF_MODE_SELECT, 32'h22);
    isp_event_src_inst.fire(9'h104);
    rd(OFF_SYNC_FAULT, 32'h0);
    repeat (3) @(posedge clk_i);
    if (exp_q.size() != 0) n_mismatch++;
    finish_test();
  end
endmodule

//--- rtl/isp_bank.sv
// Input synchronisation parameter bank with Avalon-MM slave, timing measurement and error counters.
`timescale 1ns/10ps
module isp_bank
  import isp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic operational_i,
  input wire logic sync0_i,
  input wire logic sync1_i,
  input wire logic cycle_start_i,
  input wire logic inputs_sampled_i,
  input wire logic inputs_available_i,
  input wire logic sm_event_missed_i,
  input wire logic cycle_overrun_i,
  input wire logic shift_too_short_i,
  input wire logic sync_late_i,
  input wire logic output_measure_i,
  output logic mode_free_run_o,
  output logic mode_sm3_event_o,
  output logic mode_dc_sync0_o,
  output logic mode_dc_sync1_o,
  output logic mode_sm2_event_o,
  output logic measuring_o,
  output logic [31:0] cycle_period_o,
  output logic sync_fault_o
);

  // Saturating addition of one clock period in nanoseconds.
  function automatic logic [31:0] isp_add_ns(input logic [31:0] value);
    logic [32:0] sum;
    sum = {1'b0, value} + {1'b0, CLK_PERIOD_NS};
    isp_add_ns = sum[32] ? 32'hFFFF_FFFF : sum[31:0];
  endfunction

  // Saturating increment of a 16-bit event counter.
  function automatic logic [15:0] isp_inc16(input logic [15:0] value);
    isp_inc16 = (value == 16'hFFFF) ? value : value + 16'h0001;
  endfunction

  // Byte-lane merge of write data into a stored word.
  function automatic logic [31:0] isp_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    isp_merge = res;
  endfunction

  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [15:0] mode_reg;
  logic [31:0] cycle_period_reg;
  logic [15:0] cmd_reg;
  logic [31:0] code_word_reg;
  logic [7:0] list_count_reg;
  logic [31:0] list_one_reg;
  logic [31:0] list_two_reg;
  logic [31:0] shift_ns_reg;
  logic [31:0] delay_ns_reg;
  logic [31:0] latency_ns_reg;
  logic [31:0] min_cycle_ns_reg;
  logic [31:0] since_sync0_reg;
  logic [31:0] since_sync1_reg;
  logic [31:0] since_sample_reg;
  logic [31:0] since_cycle_reg;
  logic measure_reg;
  logic [15:0] missed_reg;
  logic [15:0] overrun_reg;
  logic [15:0] short_reg;
  logic err_seen_reg;
  logic fault_reg;
  logic [5:0] mode_dec_reg;
  logic [31:0] rdata_next;

  // Bus request decoding; an access completes on the edge where waitrequest is low.
  wire bus_req = avs_read_i | avs_write_i;
  wire bus_write = avs_write_i & ~wait_reg;
  wire [7:0] addr_b = {1'b0, avs_address_i[ADDR_W-1:2], 2'b00};
  wire [31:0] mode_wr_word = isp_merge({16'h0000, mode_reg}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] cmd_wr_word = isp_merge({16'h0000, cmd_reg}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] list_cnt_word = isp_merge({24'h000000, list_count_reg}, avs_writedata_i, avs_byteenable_i);
  wire wr_mode = bus_write && (addr_b == {2'b00, OFF_MODE_SELECT});
  wire wr_period = bus_write && (addr_b == {2'b00, OFF_CYCLE_PERIOD});
  wire wr_cmd = bus_write && (addr_b == {2'b00, OFF_MEASURE_CMD});
  wire wr_code = bus_write && (addr_b == IDX_CODE_WORD);
  wire wr_list_cnt = bus_write && (addr_b == IDX_LIST_COUNT);
  wire wr_list_one = bus_write && (addr_b == IDX_LIST_ONE);
  wire wr_list_two = bus_write && (addr_b == IDX_LIST_TWO);

  // Only the documented mode codes are accepted; any other value keeps the old mode.
  wire [15:0] mode_new = mode_wr_word[15:0];
  wire mode_valid = (mode_new == MODE_FREE_RUN) || (mode_new == MODE_SM3_EVENT) ||
                    (mode_new == MODE_DC_SYNC0) || (mode_new == MODE_DC_SYNC1) ||
                    (mode_new == MODE_SM2_EVENT);
  wire dc_mode = (mode_reg == MODE_DC_SYNC0) || (mode_reg == MODE_DC_SYNC1);

  // Measurement runs while either command entry is 1; a fresh start clears the maxima.
  wire [15:0] cmd_next = wr_cmd ? cmd_wr_word[15:0] : cmd_reg;
  wire measure_next = (cmd_next == 16'h0001) || output_measure_i;
  wire measure_start = measure_next && !measure_reg;
  wire dc_measure = measure_reg && dc_mode;

  // Supported-modes map taken from its reset value and split into its documented fields.
  wire [15:0] supported_map = RST_SUPPORTED_MAP;
  wire map_free_run = supported_map[MAP_FREE_RUN_BIT];
  wire map_sm_event = supported_map[MAP_SM_EVENT_BIT];
  wire map_dc = (supported_map[MAP_DC_LSB +: 2] == MAP_DC_SUPPORTED);
  wire [1:0] map_shift = supported_map[MAP_SHIFT_LSB +: 2];
  wire map_dynamic = supported_map[MAP_DYNAMIC_BIT];

  // Read multiplexer; unmapped addresses read as zero and narrow entries are zero-extended.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (addr_b == {2'b00, OFF_GROUP_HEADER}) begin
      rdata_next = {24'h000000, RST_GROUP_HEADER};
    end else if (addr_b == {2'b00, OFF_MODE_SELECT}) begin
      rdata_next = {16'h0000, mode_reg};
    end else if (addr_b == {2'b00, OFF_CYCLE_PERIOD}) begin
      rdata_next = cycle_period_reg;
    end else if (addr_b == {2'b00, OFF_SHIFT_NS}) begin
      rdata_next = shift_ns_reg;
    end else if (addr_b == {2'b00, OFF_SUPPORTED_MAP}) begin
      rdata_next = {16'h0000, supported_map};
    end else if (addr_b == {2'b00, OFF_MIN_CYCLE_NS}) begin
      rdata_next = min_cycle_ns_reg;
    end else if (addr_b == {2'b00, OFF_LATENCY_NS}) begin
      rdata_next = latency_ns_reg;
    end else if (addr_b == {2'b00, OFF_MEASURE_CMD}) begin
      rdata_next = {16'h0000, cmd_reg};
    end else if (addr_b == {2'b00, OFF_SYNC1_DELAY_NS}) begin
      rdata_next = delay_ns_reg;
    end else if (addr_b == {2'b00, OFF_MISSED_COUNT}) begin
      rdata_next = {16'h0000, missed_reg};
    end else if (addr_b == {2'b00, OFF_OVERRUN_COUNT}) begin
      rdata_next = {16'h0000, overrun_reg};
    end else if (addr_b == {2'b00, OFF_SHORT_SHIFT_COUNT}) begin
      rdata_next = {16'h0000, short_reg};
    end else if (addr_b == {2'b00, OFF_SYNC_FAULT}) begin
      rdata_next = {31'h0000_0000, fault_reg};
    end else if (addr_b == {2'b00, OFF_PROFILE_HEADER}) begin
      rdata_next = {24'h000000, RST_PROFILE_HEADER};
    end else if (addr_b == {2'b00, OFF_CHANNEL_SPACING}) begin
      rdata_next = {16'h0000, RST_CHANNEL_SPACING};
    end else if (addr_b == {2'b00, OFF_CHANNEL_COUNT}) begin
      rdata_next = {16'h0000, RST_CHANNEL_COUNT};
    end else if (addr_b == IDX_CODE_WORD) begin
      rdata_next = code_word_reg;
    end else if (addr_b == IDX_LIST_COUNT) begin
      rdata_next = {24'h000000, list_count_reg};
    end else if (addr_b == IDX_LIST_ONE) begin
      rdata_next = list_one_reg;
    end else if (addr_b == IDX_LIST_TWO) begin
      rdata_next = list_two_reg;
    end
  end

  // One wait state per access: waitrequest drops for one cycle, then rises again.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= !(bus_req && wait_reg);
      if (avs_read_i && wait_reg) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Writable entries; read-only entries have no write path at all.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_reg <= RST_MODE_SELECT;
      cycle_period_reg <= 32'h0000_0000;
      cmd_reg <= 16'h0000;
    end else begin
      if (wr_mode && mode_valid) begin
        mode_reg <= mode_new;
      end
      if (wr_period) begin
        cycle_period_reg <= isp_merge(cycle_period_reg, avs_writedata_i, avs_byteenable_i);
      end
      cmd_reg <= cmd_next;
    end
  end

  // Profile code word and module list, kept as plain storage.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_word_reg <= 32'h0000_0000;
      list_count_reg <= RST_LIST_COUNT;
      list_one_reg <= RST_LIST_ONE;
      list_two_reg <= RST_LIST_TWO;
    end else begin
      if (wr_code) begin
        code_word_reg <= isp_merge(code_word_reg, avs_writedata_i, avs_byteenable_i);
      end
      if (wr_list_cnt) begin
        list_count_reg <= list_cnt_word[7:0];
      end
      if (wr_list_one) begin
        list_one_reg <= isp_merge(list_one_reg, avs_writedata_i, avs_byteenable_i);
      end
      if (wr_list_two) begin
        list_two_reg <= isp_merge(list_two_reg, avs_writedata_i, avs_byteenable_i);
      end
    end
  end

  // Free-running nanosecond timers, each restarted by its own reference event.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      since_sync0_reg <= 32'h0000_0000;
      since_sync1_reg <= 32'h0000_0000;
      since_sample_reg <= 32'h0000_0000;
      since_cycle_reg <= 32'h0000_0000;
    end else begin
      since_sync0_reg <= sync0_i ? 32'h0000_0000 : isp_add_ns(since_sync0_reg);
      since_sync1_reg <= sync1_i ? 32'h0000_0000 : isp_add_ns(since_sync1_reg);
      since_sample_reg <= inputs_sampled_i ? 32'h0000_0000 : isp_add_ns(since_sample_reg);
      since_cycle_reg <= cycle_start_i ? 32'h0000_0000 : isp_add_ns(since_cycle_reg);
    end
  end

  // Maximum-hold timing entries, cleared when a new measurement starts.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      measure_reg <= 1'b0;
      shift_ns_reg <= 32'h0000_0000;
      delay_ns_reg <= 32'h0000_0000;
      latency_ns_reg <= 32'h0000_0000;
      min_cycle_ns_reg <= 32'h0000_0000;
    end else begin
      measure_reg <= measure_next;
      if (measure_start) begin
        shift_ns_reg <= 32'h0000_0000;
        delay_ns_reg <= 32'h0000_0000;
        latency_ns_reg <= 32'h0000_0000;
        min_cycle_ns_reg <= 32'h0000_0000;
      end else begin
        if (dc_measure && inputs_sampled_i && (since_sync0_reg > shift_ns_reg)) begin
          shift_ns_reg <= since_sync0_reg;
        end
        if (dc_measure && inputs_sampled_i && (since_sync1_reg > delay_ns_reg)) begin
          delay_ns_reg <= since_sync1_reg;
        end
        if (dc_measure && inputs_available_i && (since_sample_reg > latency_ns_reg)) begin
          latency_ns_reg <= since_sample_reg;
        end
        if (measure_reg && inputs_available_i && (since_cycle_reg > min_cycle_ns_reg)) begin
          min_cycle_ns_reg <= since_cycle_reg;
        end
      end
    end
  end

  // Error counters, active only while the device is operational.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      missed_reg <= 16'h0000;
      overrun_reg <= 16'h0000;
      short_reg <= 16'h0000;
    end else begin
      if (operational_i && dc_mode && sm_event_missed_i) begin
        missed_reg <= isp_inc16(missed_reg);
      end
      if (operational_i && cycle_overrun_i) begin
        overrun_reg <= isp_inc16(overrun_reg);
      end
      if (operational_i && dc_mode && shift_too_short_i) begin
        short_reg <= isp_inc16(short_reg);
      end
    end
  end

  // Late-sync events collect over a cycle; the flag reflects the cycle just finished.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_seen_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      if (cycle_start_i) begin
        fault_reg <= dc_mode && (err_seen_reg || sync_late_i);
        err_seen_reg <= 1'b0;
      end else if (sync_late_i) begin
        err_seen_reg <= 1'b1;
      end
    end
  end

  // Registered decode of the selected mode for the sampling logic.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_dec_reg <= 6'h00;
    end else begin
      mode_dec_reg[0] <= (mode_reg == MODE_FREE_RUN) && map_free_run;
      mode_dec_reg[1] <= (mode_reg == MODE_SM3_EVENT) && map_sm_event;
      mode_dec_reg[2] <= (mode_reg == MODE_DC_SYNC0) && map_dc;
      mode_dec_reg[3] <= (mode_reg == MODE_DC_SYNC1) && map_dc &&
                         ((map_shift == MAP_SHIFT_SYNC1) || (map_shift != MAP_SHIFT_LOCAL) || map_dynamic);
      mode_dec_reg[4] <= (mode_reg == MODE_SM2_EVENT) && map_sm_event;
      mode_dec_reg[5] <= 1'b0;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign mode_free_run_o = mode_dec_reg[0];
  assign mode_sm3_event_o = mode_dec_reg[1];
  assign mode_dc_sync0_o = mode_dec_reg[2];
  assign mode_dc_sync1_o = mode_dec_reg[3];
  assign mode_sm2_event_o = mode_dec_reg[4];
  assign measuring_o = measure_reg;
  assign cycle_period_o = cycle_period_reg;
  assign sync_fault_o = fault_reg;

endmodule

//--- rtl/isp_pkg.sv
// Constants, register map and reset values of the input synchronisation parameter bank.
// Operation
// - Sync mode 0 free run, 1 SM3 event, 2 SYNC0, 3 SYNC1, 34 SM2 event.
// - DC mode only: read-only ns interval from SYNC0 to input sampling.
// - Supported map: bit0 free run, bit1 SM event, bits 2-3 = 01 DC mode.
// - Supported map bits 4-5: 01 local event shift, 10 shift with SYNC1.
// - Supported map bit 14: dynamic times, measured when either command entry is written.
// - DC mode only: read-only ns time from sampling until inputs reach the master.
// - DC mode only: read-only ns delay from SYNC1 until inputs are sampled.
// - Group header is read-only and returns 0x20.
// - Read-only index spacing of 16 between successive channel objects.
// - Read-only channel count of two.
// - Command 1 starts, 0 stops measurement; maxima kept, cleared per new measurement.
// - DC mode and operational: count missed SM events, read-only 16-bit.
// - Operational: count cycles overrun or started too early, read-only.
// - DC mode only: read-only flag set when last cycle synchronisation was wrong.
package isp_pkg;
  localparam logic [31:0] CLK_PERIOD_NS = 32'h0000_0064;
  localparam int ADDR_W = 7;
  localparam logic [5:0] OFF_GROUP_HEADER = 6'h00;
  localparam logic [5:0] OFF_MODE_SELECT = 6'h04;
  localparam logic [5:0] OFF_CYCLE_PERIOD = 6'h08;
  localparam logic [5:0] OFF_SHIFT_NS = 6'h0C;
  localparam logic [5:0] OFF_SUPPORTED_MAP = 6'h10;
  localparam logic [5:0] OFF_MIN_CYCLE_NS = 6'h14;
  localparam logic [5:0] OFF_LATENCY_NS = 6'h18;
  localparam logic [5:0] OFF_MEASURE_CMD = 6'h1C;
  localparam logic [5:0] OFF_SYNC1_DELAY_NS = 6'h20;
  localparam logic [5:0] OFF_MISSED_COUNT = 6'h24;
  localparam logic [5:0] OFF_OVERRUN_COUNT = 6'h28;
  localparam logic [5:0] OFF_SHORT_SHIFT_COUNT = 6'h2C;
  localparam logic [5:0] OFF_SYNC_FAULT = 6'h30;
  localparam logic [5:0] OFF_PROFILE_HEADER = 6'h34;
  localparam logic [5:0] OFF_CHANNEL_SPACING = 6'h38;
  localparam logic [5:0] OFF_CHANNEL_COUNT = 6'h3C;
  localparam logic [7:0] IDX_CODE_WORD = 8'h40;
  localparam logic [7:0] IDX_LIST_COUNT = 8'h44;
  localparam logic [7:0] IDX_LIST_ONE = 8'h48;
  localparam logic [7:0] IDX_LIST_TWO = 8'h4C;
  localparam logic [7:0] RST_GROUP_HEADER = 8'h20;
  localparam logic [15:0] RST_MODE_SELECT = 16'h0022;
  localparam logic [15:0] RST_SUPPORTED_MAP = 16'hC007;
  localparam logic [7:0] RST_PROFILE_HEADER = 8'h02;
  localparam logic [15:0] RST_CHANNEL_SPACING = 16'h0010;
  localparam logic [15:0] RST_CHANNEL_COUNT = 16'h0002;
  localparam logic [7:0] RST_LIST_COUNT = 8'h02;
  localparam logic [31:0] RST_LIST_ONE = 32'h0000_01FE;
  localparam logic [31:0] RST_LIST_TWO = 32'h0000_01FF;
  localparam logic [15:0] MODE_FREE_RUN = 16'h0000;
  localparam logic [15:0] MODE_SM3_EVENT = 16'h0001;
  localparam logic [15:0] MODE_DC_SYNC0 = 16'h0002;
  localparam logic [15:0] MODE_DC_SYNC1 = 16'h0003;
  localparam logic [15:0] MODE_SM2_EVENT = 16'h0022;
  localparam int MAP_FREE_RUN_BIT = 0;
  localparam int MAP_SM_EVENT_BIT = 1;
  localparam int MAP_DC_LSB = 2;
  localparam int MAP_SHIFT_LSB = 4;
  localparam int MAP_DYNAMIC_BIT = 14;
  localparam logic [1:0] MAP_DC_SUPPORTED = 2'h1;
  localparam logic [1:0] MAP_SHIFT_LOCAL = 2'h1;
  localparam logic [1:0] MAP_SHIFT_SYNC1 = 2'h2;
endpackage
